// >>> design/atw_pkg.sv
package atw_pkg;
   typedef enum logic [1:0] {ATW_SW, ATW_HW_NOWAIT, ATW_HW_WAIT} atw_trig_e;
   typedef enum logic [1:0] {ATW_REF_VDD, ATW_REF_EXT, ATW_REF_INT,
                             ATW_REF_BAD} atw_pref_e;
   typedef struct packed {
      logic [4:0] chan;
      logic       internal;
      logic       valid;
   } atw_route_s;
   typedef struct packed {
      logic [9:0] value;
      logic       eight_bit;
   } atw_result_s;
endpackage

// >>> design/atw_regs.svh
`ifndef ATW_REGS_SVH
`define ATW_REGS_SVH
`define ATW_OFS_MODE_ZERO  12'h000
`define ATW_OFS_MODE_ONE   12'h004
`define ATW_OFS_MODE_TWO   12'h008
`define ATW_OFS_UPPER      12'h00c
`define ATW_OFS_LOWER      12'h010
`define ATW_OFS_CHAN       12'h014
`define ATW_OFS_RESULT     12'h018
`define ATW_OFS_STATUS     12'h01c
`define ATW_OFS_MASK       12'h020
`define ATW_OFS_STATE      12'h024
`define ATW_RST_ZERO       8'h00
`define ATW_RST_ONE        8'h00
`define ATW_RST_TWO        8'h00
`define ATW_RST_UPPER      8'hff
`define ATW_RST_LOWER      8'h00
`define ATW_RST_CHAN       8'h00
`define ATW_MASK_ONE       8'he3
`define ATW_MASK_TWO       8'he9
`define ATW_MASK_CHAN      8'h9f
`define ATW_BIT_CE         0
`define ATW_BIT_RUN        7
`define ATW_BIT_SCAN       6
`define ATW_BIT_ONESHOT    5
`define ATW_BIT_CRK        3
`define ATW_BIT_TYP        0
`define ATW_BIT_ISS        7
`define ATW_IRQ_DONE       0
`define ATW_IRQ_PROHIB     1
`define ATW_CONV_NS        2000
`define ATW_CLK_NS         25
`define ATW_CONV_CYC       ((`ATW_CONV_NS + `ATW_CLK_NS - 1) / `ATW_CLK_NS)
`endif

// >>> design/atw_sync.sv
`timescale 1ns/1ps
module atw_sync
   import atw_pkg::*;
(
   input  wire logic       REF_CLK_IN,
   input  wire logic       RST_N_IN,
   input  wire logic [3:0] PIN_IN,
   output logic      [3:0] RISE_OUT
);
   // three stages; a change counts once stages two and three agree
   logic [3:0] s1_r, s2_r, s3_r, q_r;
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
         q_r  <= 4'h0;
      end else begin
         s1_r <= PIN_IN;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= q_r ^ (~(s2_r ^ s3_r) & (s3_r ^ q_r));
      end
   end
   // rising edge of the filtered level
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_edge
         assign RISE_OUT[g] = (s2_r[g] == s3_r[g]) & s3_r[g] & ~q_r[g];
      end
   endgenerate
endmodule

// >>> design/atw_top.sv
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "atw_regs.svh"
module atw_top
   import atw_pkg::*;
(
   input  wire logic        REF_CLK_IN,
   input  wire logic        RST_N_IN,
   input  wire logic [11:0] S_AXI_AWADDR_IN,
   input  wire logic        S_AXI_AWVALID_IN,
   output logic             S_AXI_AWREADY_OUT,
   input  wire logic [31:0] S_AXI_WDATA_IN,
   input  wire logic [3:0]  S_AXI_WSTRB_IN,
   input  wire logic        S_AXI_WVALID_IN,
   output logic             S_AXI_WREADY_OUT,
   output logic [1:0]       S_AXI_BRESP_OUT,
   output logic             S_AXI_BVALID_OUT,
   input  wire logic        S_AXI_BREADY_IN,
   input  wire logic [11:0] S_AXI_ARADDR_IN,
   input  wire logic        S_AXI_ARVALID_IN,
   output logic             S_AXI_ARREADY_OUT,
   output logic [31:0]      S_AXI_RDATA_OUT,
   output logic [1:0]       S_AXI_RRESP_OUT,
   output logic             S_AXI_RVALID_OUT,
   input  wire logic        S_AXI_RREADY_IN,
   input  wire logic        TIMER_CH1_IRQ_IN,
   input  wire logic        EVENT_LINK_IN,
   input  wire logic        RTC_IRQ_IN,
   input  wire logic        INTERVAL_TIMER_IRQ_IN,
   input  wire logic [9:0]  CONVERSION_RESULT_IN,
   output logic             CONV_START_OUT,
   output atw_route_s       ROUTE_OUT,
   output logic [1:0]       POS_REF_SEL_OUT,
   output logic             NEG_REF_SEL_OUT,
   output logic             COMPARATOR_ENABLE_OUT,
   output logic             SCAN_MODE_OUT,
   output logic             CONV_DONE_IRQ_OUT,
   output logic             IRQ_OUT
);
   logic [7:0] mode_zero_r, mode_one_r, mode_two_r;
   logic [7:0] upper_r, lower_r, chan_r;
   logic [1:0] status_r, mask_r;
   logic [9:0] result_r;
   logic       aw_hold_r, w_hold_r;
   logic [11:0] awaddr_r;
   logic [31:0] wdata_r;
   logic        wstrb0_r;
   logic [3:0] rise;
   logic       busy_r, pass, trig_sel, sw_start, hw_start;
   logic [7:0] cnt_r;
   atw_trig_e  tmode;
   atw_route_s route_nxt;
   logic       wr_go, rd_go;

   // field decode used at start and in the state readback
   function automatic atw_trig_e trig_of(input logic [7:0] m);
      if (!m[7])
         trig_of = ATW_SW;
      else if (!m[6])
         trig_of = ATW_HW_NOWAIT;
      else
         trig_of = ATW_HW_WAIT;
   endfunction

   // external and internal channel legality
   function automatic logic chan_ok(input logic [7:0] c, input logic [1:0] p);
      if (!c[`ATW_BIT_ISS])
         chan_ok = (c[4:0] <= 5'h0e)
                   || (c[4:0] >= 5'h10 && c[4:0] <= 5'h14);
      else
         chan_ok = (c[4:1] == 4'h0) && !(c[0] == 1'b0 && p == 2'b10);
   endfunction

   assign tmode = trig_of(mode_one_r);

   atw_sync u_sync (
      .REF_CLK_IN (REF_CLK_IN),
      .RST_N_IN   (RST_N_IN),
      .PIN_IN     ({INTERVAL_TIMER_IRQ_IN, RTC_IRQ_IN, EVENT_LINK_IN,
                    TIMER_CH1_IRQ_IN}),
      .RISE_OUT   (rise)
   );

   atw_window u_win (
      .UPPER_IN   (upper_r),
      .LOWER_IN   (lower_r),
      .RES_IN     ({CONVERSION_RESULT_IN, mode_two_r[`ATW_BIT_TYP]}),
      .OUTSIDE_IN (mode_two_r[`ATW_BIT_CRK]),
      .PASS_OUT   (pass)
   );

   // trigger source mux
   assign trig_sel = rise[mode_one_r[1:0]];
   assign hw_start = (tmode != ATW_SW) && mode_zero_r[`ATW_BIT_CE] && trig_sel
                     && !busy_r;
   assign sw_start = (tmode == ATW_SW) && mode_zero_r[`ATW_BIT_RUN]
                     && mode_zero_r[`ATW_BIT_CE] && !busy_r;
   assign route_nxt = '{chan: chan_r[4:0], internal: chan_r[`ATW_BIT_ISS],
                        valid: chan_ok(chan_r, mode_two_r[7:6])};

   // axi handshakes: hold address and data until both present
   assign S_AXI_AWREADY_OUT = !aw_hold_r && !S_AXI_BVALID_OUT;
   assign S_AXI_WREADY_OUT  = !w_hold_r && !S_AXI_BVALID_OUT;
   assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
   assign wr_go = aw_hold_r && w_hold_r;
   assign rd_go = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         aw_hold_r        <= 1'b0;
         w_hold_r         <= 1'b0;
         awaddr_r         <= 12'h000;
         wdata_r          <= 32'h0;
         wstrb0_r         <= 1'b0;
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT  <= 2'b00;
      end else begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= S_AXI_AWADDR_IN;
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_hold_r <= 1'b1;
            wdata_r  <= S_AXI_WDATA_IN;
            wstrb0_r <= S_AXI_WSTRB_IN[0]; // strobe may drop after handshake
         end
         if (wr_go) begin
            aw_hold_r        <= 1'b0;
            w_hold_r         <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT  <= (awaddr_r > `ATW_OFS_MASK) ? 2'b10 : 2'b00;
         end else if (S_AXI_BREADY_IN)
            S_AXI_BVALID_OUT <= 1'b0;
      end
   end

   // register writes; byte lane 0 only, reserved bits of mode_one_r, mode_two_r and chan_r held at zero
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         mode_zero_r <= `ATW_RST_ZERO;
         mode_one_r  <= `ATW_RST_ONE;
         mode_two_r  <= `ATW_RST_TWO;
         upper_r     <= `ATW_RST_UPPER;
         lower_r     <= `ATW_RST_LOWER;
         chan_r      <= `ATW_RST_CHAN;
         mask_r      <= 2'b00;
      end else begin
         if (wr_go && wstrb0_r) begin
            if (awaddr_r == `ATW_OFS_MODE_ZERO)
               mode_zero_r <= wdata_r[7:0];
            else if (awaddr_r == `ATW_OFS_MODE_ONE)
               mode_one_r <= wdata_r[7:0] & `ATW_MASK_ONE;
            else if (awaddr_r == `ATW_OFS_MODE_TWO)
               mode_two_r <= wdata_r[7:0] & `ATW_MASK_TWO;
            else if (awaddr_r == `ATW_OFS_UPPER)
               upper_r <= wdata_r[7:0];
            else if (awaddr_r == `ATW_OFS_LOWER)
               lower_r <= wdata_r[7:0];
            else if (awaddr_r == `ATW_OFS_CHAN)
               chan_r <= wdata_r[7:0] & `ATW_MASK_CHAN;
            else if (awaddr_r == `ATW_OFS_MASK)
               mask_r <= wdata_r[1:0];
         end
         // one-shot software run clears itself once started
         if (sw_start && mode_one_r[`ATW_BIT_ONESHOT])
            mode_zero_r[`ATW_BIT_RUN] <= 1'b0;
      end
   end

   // conversion timing and channel latch
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         busy_r         <= 1'b0;
         cnt_r          <= 8'h00;
         CONV_START_OUT <= 1'b0;
         ROUTE_OUT      <= '0;
         result_r       <= 10'h000;
      end else begin
         CONV_START_OUT <= hw_start || sw_start;
         if (hw_start || sw_start) begin
            busy_r    <= 1'b1;
            cnt_r     <= 8'(`ATW_CONV_CYC);
            ROUTE_OUT <= route_nxt;
         end else if (busy_r) begin
            if (cnt_r == 8'h01) begin
               busy_r   <= 1'b0;
               result_r <= mode_two_r[`ATW_BIT_TYP] ?
                           {2'b00, CONVERSION_RESULT_IN[7:0]} :
                           CONVERSION_RESULT_IN;
            end
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end

   // sticky events; set wins over write-one clear
   logic done_ev, bad_ev;
   assign done_ev = busy_r && (cnt_r == 8'h01) && pass;
   assign bad_ev  = (hw_start || sw_start) && (!route_nxt.valid
                    || mode_two_r[7:6] == 2'b11);
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN)
         status_r <= 2'b00;
      else begin
         if (wr_go && wstrb0_r && awaddr_r == `ATW_OFS_STATUS)
            status_r <= status_r & ~wdata_r[1:0];
         if (done_ev)
            status_r[`ATW_IRQ_DONE] <= 1'b1;
         if (bad_ev)
            status_r[`ATW_IRQ_PROHIB] <= 1'b1;
      end
   end
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         CONV_DONE_IRQ_OUT <= 1'b0;
         IRQ_OUT           <= 1'b0;
      end else begin
         CONV_DONE_IRQ_OUT <= done_ev;
         IRQ_OUT <= |(status_r & mask_r);
      end
   end

   // static selections toward the analog side
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         POS_REF_SEL_OUT       <= 2'b00;
         NEG_REF_SEL_OUT       <= 1'b0;
         COMPARATOR_ENABLE_OUT <= 1'b0;
         SCAN_MODE_OUT         <= 1'b0;
      end else begin
         POS_REF_SEL_OUT <= (mode_two_r[7:6] == 2'b11) ? 2'b00
                            : mode_two_r[7:6];
         NEG_REF_SEL_OUT       <= mode_two_r[5];
         COMPARATOR_ENABLE_OUT <= mode_zero_r[`ATW_BIT_CE];
         SCAN_MODE_OUT         <= mode_zero_r[`ATW_BIT_SCAN];
      end
   end

   // read channel; unmapped reads return slverr
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT  <= 32'h0;
         S_AXI_RRESP_OUT  <= 2'b00;
      end else if (rd_go) begin
         S_AXI_RVALID_OUT <= 1'b1;
         S_AXI_RRESP_OUT  <= 2'b00;
         if (S_AXI_ARADDR_IN == `ATW_OFS_MODE_ZERO)
            S_AXI_RDATA_OUT <= {24'h0, mode_zero_r};
         else if (S_AXI_ARADDR_IN == `ATW_OFS_MODE_ONE)
            S_AXI_RDATA_OUT <= {24'h0, mode_one_r};
         else if (S_AXI_ARADDR_IN == `ATW_OFS_MODE_TWO)
            S_AXI_RDATA_OUT <= {24'h0, mode_two_r};
         else if (S_AXI_ARADDR_IN == `ATW_OFS_UPPER)
            S_AXI_RDATA_OUT <= {24'h0, upper_r};
         else if (S_AXI_ARADDR_IN == `ATW_OFS_LOWER)
            S_AXI_RDATA_OUT <= {24'h0, lower_r};
         else if (S_AXI_ARADDR_IN == `ATW_OFS_CHAN)
            S_AXI_RDATA_OUT <= {24'h0, chan_r};
         else if (S_AXI_ARADDR_IN == `ATW_OFS_RESULT)
            S_AXI_RDATA_OUT <= {22'h0, result_r};
         else if (S_AXI_ARADDR_IN == `ATW_OFS_STATUS)
            S_AXI_RDATA_OUT <= {30'h0, status_r};
         else if (S_AXI_ARADDR_IN == `ATW_OFS_MASK)
            S_AXI_RDATA_OUT <= {30'h0, mask_r};
         else if (S_AXI_ARADDR_IN == `ATW_OFS_STATE)
            S_AXI_RDATA_OUT <= {29'h0, busy_r, tmode};
         else begin
            S_AXI_RDATA_OUT <= 32'h0;
            S_AXI_RRESP_OUT <= 2'b10;
         end
      end else if (S_AXI_RREADY_IN)
         S_AXI_RVALID_OUT <= 1'b0;
   end

   // checks
   start_needs_ce_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!RST_N_IN) CONV_START_OUT |-> $past(mode_zero_r[0]))
      else $error("start without comparator enable");
   hw_start_trig_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!RST_N_IN) hw_start |-> mode_one_r[7] && trig_sel)
      else $error("hardware start without trigger");
   route_latch_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!RST_N_IN)
      hw_start |=> ROUTE_OUT.chan == $past(chan_r[4:0]))
      else $error("channel not latched");
   trig_mode_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!RST_N_IN)
      mode_one_r[7:6] == 2'b10 |-> tmode == ATW_HW_NOWAIT)
      else $error("trigger mode decode wrong");
   inside_irq_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!RST_N_IN) done_ev && !mode_two_r[3] |->
      lower_r <= (mode_two_r[0] ? CONVERSION_RESULT_IN[7:0]
                                : CONVERSION_RESULT_IN[9:2]))
      else $error("inside window violated");
   outside_irq_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!RST_N_IN) busy_r && cnt_r == 8'h01 && mode_two_r[3]
      && upper_r == 8'h00 |-> done_ev)
      else $error("outside window missed");
   irq_pulse_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!RST_N_IN)
      done_ev |=> CONV_DONE_IRQ_OUT ##1 !CONV_DONE_IRQ_OUT)
      else $error("done pulse wrong");
   ref_out_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!RST_N_IN) ##1 POS_REF_SEL_OUT != 2'b11)
      else $error("prohibited reference driven");
   neg_ref_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!RST_N_IN) NEG_REF_SEL_OUT == $past(mode_two_r[5]))
      else $error("negative reference lag");
   conv_c: cover property (@(posedge REF_CLK_IN) hw_start ##[1:200] done_ev);
   sw_c: cover property (@(posedge REF_CLK_IN) sw_start);
   bad_c: cover property (@(posedge REF_CLK_IN) bad_ev);
endmodule

// >>> design/atw_window.sv
`timescale 1ns/1ps
module atw_window
   import atw_pkg::*;
(
   input  wire logic        [7:0] UPPER_IN,
   input  wire logic        [7:0] LOWER_IN,
   input  wire atw_result_s       RES_IN,
   input  wire logic              OUTSIDE_IN,
   output logic                   PASS_OUT
);
   // eight-bit results arrive in the low bits; ten-bit compares bits 9:2
   logic [7:0] top;
   always_comb begin
      top = RES_IN.eight_bit ? RES_IN.value[7:0] : RES_IN.value[9:2];
      if (!OUTSIDE_IN)
         PASS_OUT = (LOWER_IN <= top) && (top <= UPPER_IN);
      else
         PASS_OUT = (top <= LOWER_IN) || (UPPER_IN <= top);
   end
endmodule

// >>> verification/test_adc_trigger_window_config.sv
`timescale 1ns/1ps
`include "atw_regs.svh"
module test_adc_trigger_window_config
   import atw_pkg::*;
();
   typedef struct packed {
      logic [1:0] src;
      logic [1:0] tm;
      logic       crk;
      logic [7:0] up;
      logic [7:0] lo;
      logic [7:0] chan;
      logic [9:0] res;
      logic       done;
   } atw_row_s;
   // window uses result bits 9:2, so 10'h043 compares as 8'h10
   localparam atw_row_s ROWS [7] = '{
      '{2'd1, 2'b10, 1'b0, 8'hff, 8'h00, 8'h00, 10'h054, 1'b1},
      '{2'd1, 2'b11, 1'b0, 8'h20, 8'h10, 8'h0e, 10'h043, 1'b1},
      '{2'd2, 2'b10, 1'b0, 8'h20, 8'h10, 8'h10, 10'h084, 1'b0},
      '{2'd3, 2'b11, 1'b0, 8'h20, 8'h10, 8'h14, 10'h080, 1'b1},
      '{2'd0, 2'b10, 1'b1, 8'h20, 8'h10, 8'h01, 10'h040, 1'b1},
      '{2'd1, 2'b10, 1'b1, 8'h20, 8'h10, 8'h80, 10'h054, 1'b0},
      '{2'd3, 2'b10, 1'b1, 8'h00, 8'h10, 8'h05, 10'h0fc, 1'b1}};
   logic        ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rd_v;
   logic [3:0]  wstrb, trg;
   logic [9:0]  res_in;
   logic [1:0]  rd_r, wr_r;
   logic        seen;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp, pos_ref;
   wire  [31:0] rdata;
   wire         conv_start, conv_done, ce_out, scan_out, neg_ref, irq;
   wire atw_route_s route;
   int          num_errors, check_count;

   atw_top u_dut (.REF_CLK_IN(ref_clk), .RST_N_IN(rst_n),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
      .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
      .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
      .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
      .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
      .S_AXI_RREADY_IN(rready), .TIMER_CH1_IRQ_IN(trg[0]),
      .EVENT_LINK_IN(trg[1]), .RTC_IRQ_IN(trg[2]),
      .INTERVAL_TIMER_IRQ_IN(trg[3]), .CONVERSION_RESULT_IN(res_in),
      .CONV_START_OUT(conv_start), .ROUTE_OUT(route),
      .POS_REF_SEL_OUT(pos_ref), .NEG_REF_SEL_OUT(neg_ref),
      .COMPARATOR_ENABLE_OUT(ce_out), .SCAN_MODE_OUT(scan_out),
      .CONV_DONE_IRQ_OUT(conv_done), .IRQ_OUT(irq));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task chk(input string what, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, e, s);
      end
   endtask

   // handshakes are seen at the rising edge, released right after it
   task wr(input logic [11:0] a, input logic [31:0] d);
      int   n;
      logic b_t;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'h1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      b_t = 1'b0;
      while (!b_t && n < 200) begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         b_t = bvalid && bready;
         if (b_t) wr_r = bresp;
         n++;
      end
      bready <= 1'b0;
      chk("write response", b_t, 1'b1);
      repeat (2) @(posedge ref_clk);
   endtask

   task rd(input logic [11:0] a);
      int   n;
      logic r_t;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      r_t = 1'b0;
      while (!r_t && n < 200) begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         r_t = rvalid && rready;
         if (r_t) begin
            rd_v = rdata;
            rd_r = rresp;
         end
         n++;
      end
      rready <= 1'b0;
      chk("read response", r_t, 1'b1);
      // one idle edge so a following read never re-raises rready at once
      @(posedge ref_clk);
   endtask

   // looks for a one-cycle pulse of start (sel 0) or done (sel 1)
   task watch(input int n, input logic sel);
      seen = 1'b0;
      repeat (n) begin
         @(negedge ref_clk);
         if ((sel ? conv_done : conv_start) === 1'b1) seen = 1'b1;
      end
      @(posedge ref_clk);
   endtask

   task conv(input atw_row_s r);
      wr(`ATW_OFS_UPPER, {24'h0, r.up});
      wr(`ATW_OFS_LOWER, {24'h0, r.lo});
      wr(`ATW_OFS_MODE_TWO, {28'h0, r.crk, 3'b000});
      wr(`ATW_OFS_MODE_ONE, {24'h0, r.tm, 1'b1, 3'b000, r.src});
      wr(`ATW_OFS_CHAN, {24'h0, r.chan});
      wr(`ATW_OFS_MODE_ZERO, 32'h1);
      res_in <= r.res;
      trg[r.src + 2'd1] <= 1'b1;
      watch(12, 1'b0);
      chk("unselected trigger", seen, 1'b0);
      trg[r.src] <= 1'b1;
      watch(12, 1'b0);
      chk("start", seen, 1'b1);
      chk("route", route, {r.chan[4:0], r.chan[7], 1'b1});
      trg <= 4'h0;
      watch(110, 1'b1);
      chk("window done", seen, r.done);
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (10000) @(posedge ref_clk);
      num_errors++;
      $display("ERROR watchdog expired");
      end_of_test;
   end

   initial begin
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, wstrb, trg, res_in} = '0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      foreach (ROWS[i]) begin
         conv(ROWS[i]);
         $display("row %0d done", i);
      end
      // status bit of last passing conversion, then unmask and clear
      rd(`ATW_OFS_STATUS);
      chk("status done", rd_v[0], 1'b1);
      chk("irq masked", irq, 1'b0);
      wr(`ATW_OFS_MASK, 32'h1);
      chk("irq unmasked", irq, 1'b1);
      wr(`ATW_OFS_STATUS, 32'h3);
      chk("irq cleared", irq, 1'b0);
      $display("interrupt test done");
      // software one-shot: run bit drops after the start
      wr(`ATW_OFS_MODE_ONE, 32'h20);
      wr(`ATW_OFS_MODE_ZERO, 32'h81);
      rd(`ATW_OFS_STATE);
      chk("state busy", rd_v, {29'h0, 1'b1, ATW_SW});
      watch(100, 1'b1);
      chk("software done", seen, 1'b1);
      rd(`ATW_OFS_RESULT);
      chk("result", rd_v, 32'h0fc);
      rd(`ATW_OFS_MODE_ZERO);
      chk("one-shot run", rd_v[7:0], 8'h01);
      // comparator stopped: hardware trigger ignored
      wr(`ATW_OFS_MODE_ONE, 32'ha1);
      wr(`ATW_OFS_MODE_ZERO, 32'h0);
      chk("comparator off", ce_out, 1'b0);
      trg[1] <= 1'b1;
      watch(12, 1'b0);
      trg <= 4'h0;
      chk("stopped start", seen, 1'b0);
      $display("software and stop test done");
      // internal reference via clear, write, re-enable
      wr(`ATW_OFS_CHAN, 32'h0);
      wr(`ATW_OFS_MODE_TWO, 32'h0);
      wr(`ATW_OFS_MODE_TWO, 32'h80);
      wr(`ATW_OFS_MODE_ZERO, 32'h41);
      chk("internal ref", pos_ref, 2'b10);
      chk("scan mode", scan_out, 1'b1);
      chk("comparator on", ce_out, 1'b1);
      wr(`ATW_OFS_MODE_TWO, 32'h0);
      wr(`ATW_OFS_MODE_TWO, 32'h60);
      chk("external refs", {pos_ref, neg_ref}, 3'b011);
      wr(`ATW_OFS_MODE_TWO, 32'h0);
      wr(`ATW_OFS_MODE_TWO, 32'hc0);
      chk("prohibited ref", pos_ref, 2'b00);
      trg[1] <= 1'b1;
      watch(12, 1'b0);
      trg <= 4'h0;
      chk("prohibited start", seen, 1'b1);
      rd(`ATW_OFS_STATUS);
      chk("prohibited flag", rd_v[1], 1'b1);
      wr(`ATW_OFS_MODE_TWO, 32'h3f);
      rd(`ATW_OFS_MODE_TWO);
      chk("mode two fields", rd_v, 32'h29);
      wr(`ATW_OFS_MODE_ONE, 32'hff);
      rd(`ATW_OFS_MODE_ONE);
      chk("mode one fields", rd_v, 32'he3);
      wr(12'h030, 32'h0);
      chk("unmapped write", wr_r, 2'b10);
      rd(12'h030);
      chk("unmapped read", rd_r, 2'b10);
      $display("reference and register test done");
      // second reset in mid-run
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd(`ATW_OFS_UPPER);
      chk("upper reset", rd_v, 32'hff);
      rd(`ATW_OFS_MODE_ONE);
      chk("mode one reset", rd_v, 32'h0);
      chk("outputs reset", {irq, ce_out, pos_ref}, 4'h0);
      $display("reset test done");
      end_of_test;
   end
endmodule
